// [logic/pcsc_cfg.svh]
/*
  Register map, field positions, reset values and counts for the PLL clock
  select control block. Included by the package users; definitions only.
*/
`ifndef PCSC_CFG_SVH
`define PCSC_CFG_SVH

// register word indices, byte address = index * 4
`define PCSC_IDX_CTRL 3'h0
`define PCSC_IDX_BW 3'h1
`define PCSC_IDX_MUL 3'h2
`define PCSC_IDX_VRS 3'h3
`define PCSC_IDX_RDS 3'h4
`define PCSC_IDX_CFG 3'h5

// control register fields
`define PCSC_CTRL_IE 7
`define PCSC_CTRL_FLAG 6
`define PCSC_CTRL_LON 5
`define PCSC_CTRL_BCS 4
`define PCSC_CTRL_PRE_HI 3
`define PCSC_CTRL_PRE_LO 2
`define PCSC_CTRL_VPR_HI 1
`define PCSC_CTRL_VPR_LO 0

// bandwidth register fields
`define PCSC_BW_AUTO 7
`define PCSC_BW_LOCK 6
`define PCSC_BW_TRK 5

// config register field
`define PCSC_CFG_KEEP 0

// reset values of the programming registers
`define PCSC_MUL_RST 12'h040
`define PCSC_VRS_RST 8'h40
`define PCSC_RDS_RST 4'h1

// source edges waited on each side of a switch
`define PCSC_SW_EDGES 2'h3

`define PCSC_RESP_OKAY 1'b0

`endif

// [logic/pcsc_pkg.sv]
/*
  Types of the PLL clock select control block: bus carriers, switch states,
  exported PLL settings and the block's whole state.
  Assumes an AHB-Lite master with 32-bit data.
*/
package pcsc_pkg;

  typedef enum logic [1:0] {
    PCSC_SW_IDLE = 2'b00,
    PCSC_SW_HOLD = 2'b01,
    PCSC_SW_COMMIT = 2'b11
  } pcsc_sw_e;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } pcsc_ahb_in_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } pcsc_ahb_out_s;

  typedef struct packed {
    logic [1:0] prescale;
    logic [1:0] vco_pow2_range;
    logic [11:0] multiplier;
    logic [7:0] vco_linear_range;
    logic [3:0] ref_divider;
    logic track_not_acquire;
    logic auto_bandwidth;
  } pcsc_settings_s;

  typedef struct packed {
    logic ie;
    logic flag;
    logic lon;
    logic base_source_select;
    logic [1:0] pre;
    logic [1:0] vpr;
    logic autob;
    logic trk;
    logic [11:0] mul;
    logic [7:0] vrs;
    logic [3:0] rds;
    logic keep;
    logic lk_s1;
    logic lk_s2;
    logic lk_d3;
    logic xp;
    logic vp;
    logic act;
    logic tgt;
    pcsc_sw_e sw;
    logic [1:0] cx;
    logic [1:0] cv;
    logic bout;
    logic irq;
    logic osc_en;
    logic loop_en;
    logic wr_pend;
    logic [2:0] wadr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
  } pcsc_state_s;

endpackage

// [logic/pcsc_top.sv]
/*
  PLL clock select control: base clock selector with glitch-free switch,
  loop-on / select interlocks, write protection of the PLL programming
  registers, lock-change flag and interrupt, bandwidth bits, stop gating.
  Assumes: all inputs synchronous to clk; crystal and VCO clocks are slow
  enough to be sampled as levels; registers reached over AHB-Lite.
*/
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`include "pcsc_cfg.svh"

module pcsc_top (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // register bus
  input wire pcsc_pkg::pcsc_ahb_in_s ahb_in,
  output pcsc_pkg::pcsc_ahb_out_s ahb_out,
  // source clocks and analog status
  input wire logic crystal_clock,
  input wire logic vco_clock,
  input wire logic lock_status,
  input wire logic track_status,
  // system integration unit
  input wire logic system_osc_enable,
  input wire logic stop_mode,
  output logic base_clock_out,
  output logic lock_change_irq,
  // analog controls
  output logic osc_enable,
  output logic loop_enable,
  output pcsc_pkg::pcsc_settings_s pll_settings
);

  pcsc_pkg::pcsc_state_s st_q;
  pcsc_pkg::pcsc_state_s st_d;
  logic [31:0] wd;
  logic [31:0] rd;
  logic [2:0] idx;
  logic mapped;
  logic acc;
  logic stopped;
  logic lk_edge;
  logic rise_x;
  logic rise_v;

  always_comb begin
    st_d = st_q;
    wd = ahb_in.hwdata;
    rd = '0;
    idx = ahb_in.haddr[4:2];
    mapped = (ahb_in.haddr[31:5] == 27'h0) && (idx <= `PCSC_IDX_CFG);
    acc = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
    stopped = stop_mode & ~st_q.keep;
    lk_edge = st_q.lk_s2 ^ st_q.lk_d3;
    rise_x = crystal_clock & ~st_q.xp;
    rise_v = vco_clock & ~st_q.vp;

    // lock status synchroniser and edge history
    st_d.lk_s1 = lock_status;
    st_d.lk_s2 = st_q.lk_s1;
    st_d.lk_d3 = st_q.lk_s2;
    st_d.xp = crystal_clock;
    st_d.vp = vco_clock;

    // data phase of a write
    if (st_q.wr_pend) begin
      case (st_q.wadr)
        `PCSC_IDX_CTRL: begin
          if (st_q.autob) begin
            st_d.ie = wd[`PCSC_CTRL_IE];
          end
          if (!st_q.lon) begin
            st_d.pre = wd[`PCSC_CTRL_PRE_HI:`PCSC_CTRL_PRE_LO];
            st_d.vpr = wd[`PCSC_CTRL_VPR_HI:`PCSC_CTRL_VPR_LO];
          end
          // both interlocks judge the old bits, so one write cannot do both
          st_d.lon = st_q.base_source_select | wd[`PCSC_CTRL_LON];
          st_d.base_source_select = st_q.lon & (st_q.vrs != 8'h00) & wd[`PCSC_CTRL_BCS];
        end
        `PCSC_IDX_BW: begin
          st_d.autob = wd[`PCSC_BW_AUTO];
          if (!st_q.autob) begin
            st_d.trk = wd[`PCSC_BW_TRK];
          end
        end
        `PCSC_IDX_MUL: begin
          if (!st_q.lon) begin
            st_d.mul = wd[11:0];
          end
        end
        `PCSC_IDX_VRS: begin
          if (!st_q.lon) begin
            st_d.vrs = wd[7:0];
          end
        end
        `PCSC_IDX_RDS: begin
          if (!st_q.lon) begin
            st_d.rds = wd[3:0];
          end
        end
        `PCSC_IDX_CFG: begin
          st_d.keep = wd[`PCSC_CFG_KEEP];
        end
        default: begin
        end
      endcase
    end
    if (!st_d.autob) begin
      st_d.ie = 1'b0;
    end
    if (!st_d.lon || st_d.vrs == 8'h00) begin
      st_d.base_source_select = 1'b0;
    end
    if (stop_mode) begin
      st_d.base_source_select = 1'b0;
    end

    // read word, taken at the address phase
    case (idx)
      `PCSC_IDX_CTRL: begin
        rd[`PCSC_CTRL_IE] = st_q.ie;
        rd[`PCSC_CTRL_FLAG] = st_q.flag & st_q.autob;
        rd[`PCSC_CTRL_LON] = st_q.lon;
        rd[`PCSC_CTRL_BCS] = st_q.base_source_select;
        rd[`PCSC_CTRL_PRE_HI:`PCSC_CTRL_PRE_LO] = st_q.pre;
        rd[`PCSC_CTRL_VPR_HI:`PCSC_CTRL_VPR_LO] = st_q.vpr;
      end
      `PCSC_IDX_BW: begin
        rd[`PCSC_BW_AUTO] = st_q.autob;
        rd[`PCSC_BW_LOCK] = st_q.lk_s2 & st_q.autob;
        rd[`PCSC_BW_TRK] = st_q.autob ? track_status : st_q.trk;
      end
      `PCSC_IDX_MUL: rd[11:0] = st_q.mul;
      `PCSC_IDX_VRS: rd[7:0] = st_q.vrs;
      `PCSC_IDX_RDS: rd[3:0] = st_q.rds;
      `PCSC_IDX_CFG: rd[`PCSC_CFG_KEEP] = st_q.keep;
      default: rd = '0;
    endcase
    if (!mapped) begin
      rd = '0;
    end

    // bus address phase
    st_d.wr_pend = acc & ahb_in.hwrite & mapped;
    st_d.wadr = idx;
    st_d.rdy = 1'b1;
    st_d.resp = `PCSC_RESP_OKAY;
    if (acc && !ahb_in.hwrite) begin
      st_d.rdata = rd;
      if (mapped && idx == `PCSC_IDX_CTRL) begin
        st_d.flag = 1'b0;
      end
    end
    if (lk_edge) begin
      st_d.flag = 1'b1;
    end

    // base clock selector
    case (st_q.sw)
      pcsc_pkg::PCSC_SW_IDLE: begin
        if (st_q.base_source_select != st_q.act) begin
          st_d.sw = pcsc_pkg::PCSC_SW_HOLD;
          st_d.tgt = st_q.base_source_select;
          st_d.cx = 2'h0;
          st_d.cv = 2'h0;
        end else if (st_q.act ? rise_v : rise_x) begin
          st_d.bout = ~st_q.bout;
        end
      end
      pcsc_pkg::PCSC_SW_HOLD: begin
        if (rise_x && st_q.cx != `PCSC_SW_EDGES) begin
          st_d.cx = st_q.cx + 2'h1;
        end
        if (rise_v && st_q.cv != `PCSC_SW_EDGES) begin
          st_d.cv = st_q.cv + 2'h1;
        end
        if (st_q.cx == `PCSC_SW_EDGES && st_q.cv == `PCSC_SW_EDGES) begin
          st_d.sw = pcsc_pkg::PCSC_SW_COMMIT;
        end
      end
      pcsc_pkg::PCSC_SW_COMMIT: begin
        st_d.act = st_q.tgt;
        st_d.sw = pcsc_pkg::PCSC_SW_IDLE;
      end
      default: st_d.sw = pcsc_pkg::PCSC_SW_IDLE;
    endcase
    if (stopped) begin
      st_d.bout = 1'b0;
    end

    st_d.irq = st_q.flag & st_q.ie & st_q.autob & ~stopped;
    st_d.osc_en = system_osc_enable | (stop_mode & st_q.keep);
    st_d.loop_en = system_osc_enable & st_q.lon & (st_q.vrs != 8'h00) & ~stop_mode;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.lon <= 1'b1;
      st_q.mul <= `PCSC_MUL_RST;
      st_q.vrs <= `PCSC_VRS_RST;
      st_q.rds <= `PCSC_RDS_RST;
      st_q.sw <= pcsc_pkg::PCSC_SW_IDLE;
      st_q.rdy <= 1'b1;
      st_q.resp <= `PCSC_RESP_OKAY;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign ahb_out.hrdata = st_q.rdata;
  assign ahb_out.hreadyout = st_q.rdy;
  assign ahb_out.hresp = st_q.resp;
  assign base_clock_out = st_q.bout;
  assign lock_change_irq = st_q.irq;
  assign osc_enable = st_q.osc_en;
  assign loop_enable = st_q.loop_en;
  assign pll_settings.prescale = st_q.pre;
  assign pll_settings.vco_pow2_range = st_q.vpr;
  assign pll_settings.multiplier = st_q.mul;
  assign pll_settings.vco_linear_range = st_q.vrs;
  assign pll_settings.ref_divider = st_q.rds;
  assign pll_settings.track_not_acquire = st_q.trk;
  assign pll_settings.auto_bandwidth = st_q.autob;

  property p_sel_forced;
    @(posedge clk) disable iff (!reset_n)
    st_q.base_source_select |-> st_q.lon && st_q.vrs != 8'h00;
  endproperty
  a_sel_forced: assert property (p_sel_forced) else $error("select set without loop");

  property p_loop_held;
    @(posedge clk) disable iff (!reset_n)
    st_q.base_source_select ##1 st_q.base_source_select |-> st_q.lon && $past(st_q.lon);
  endproperty
  a_loop_held: assert property (p_loop_held) else $error("loop dropped under select");

  property p_ie_manual;
    @(posedge clk) disable iff (!reset_n)
    !st_q.autob |-> !st_q.ie;
  endproperty
  a_ie_manual: assert property (p_ie_manual) else $error("enable set in manual mode");

  property p_flag_set;
    @(posedge clk) disable iff (!reset_n)
    clk_en && (st_q.lk_s2 != st_q.lk_d3) |=> st_q.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("lock change not flagged");

  property p_flag_clear;
    @(posedge clk) disable iff (!reset_n)
    clk_en && acc && !ahb_in.hwrite && mapped && idx == `PCSC_IDX_CTRL
      && st_q.lk_s2 == st_q.lk_d3 |=> !st_q.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("read did not clear flag");

  property p_irq;
    @(posedge clk) disable iff (!reset_n)
    clk_en && st_q.flag && st_q.ie && st_q.autob && !stopped |=> lock_change_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_pre_frozen;
    @(posedge clk) disable iff (!reset_n)
    st_q.lon |=> $stable(st_q.pre);
  endproperty
  a_pre_frozen: assert property (p_pre_frozen) else $error("prescaler changed");

  property p_vpr_frozen;
    @(posedge clk) disable iff (!reset_n)
    st_q.lon |=> $stable(st_q.vpr);
  endproperty
  a_vpr_frozen: assert property (p_vpr_frozen) else $error("range exponent changed");

  property p_prog_frozen;
    @(posedge clk) disable iff (!reset_n)
    st_q.lon |=> $stable(st_q.mul) && $stable(st_q.vrs) && $stable(st_q.rds);
  endproperty
  a_prog_frozen: assert property (p_prog_frozen) else $error("programming changed");

  property p_hold;
    @(posedge clk) disable iff (!reset_n)
    st_q.sw != pcsc_pkg::PCSC_SW_IDLE && !stopped |=> $stable(base_clock_out);
  endproperty
  a_hold: assert property (p_hold) else $error("base clock moved in switch");

  property p_toggle;
    @(posedge clk) disable iff (!reset_n)
    clk_en && st_q.sw == pcsc_pkg::PCSC_SW_IDLE && st_q.base_source_select == st_q.act && !stopped
      && (st_q.act ? rise_v : rise_x) |=> base_clock_out != $past(base_clock_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("base clock missed edge");

  property p_stop_clear;
    @(posedge clk) disable iff (!reset_n)
    clk_en && stop_mode |=> !st_q.base_source_select;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("select kept in stop");

  property p_flag_manual;
    @(posedge clk) disable iff (!reset_n)
    clk_en && acc && !ahb_in.hwrite && mapped && idx == `PCSC_IDX_CTRL && !st_q.autob
      |=> !ahb_out.hrdata[`PCSC_CTRL_FLAG];
  endproperty
  a_flag_manual: assert property (p_flag_manual) else $error("flag seen in manual");

  property p_lock_manual;
    @(posedge clk) disable iff (!reset_n)
    clk_en && acc && !ahb_in.hwrite && mapped && idx == `PCSC_IDX_BW && !st_q.autob
      |=> !ahb_out.hrdata[`PCSC_BW_LOCK];
  endproperty
  a_lock_manual: assert property (p_lock_manual) else $error("lock seen in manual");

  property p_auto_write;
    @(posedge clk) disable iff (!reset_n)
    clk_en && st_q.wr_pend && st_q.wadr == `PCSC_IDX_BW
      |=> st_q.autob == $past(ahb_in.hwdata[`PCSC_BW_AUTO]);
  endproperty
  a_auto_write: assert property (p_auto_write) else $error("auto bit not written");

  property p_trk_write;
    @(posedge clk) disable iff (!reset_n)
    clk_en && st_q.wr_pend && st_q.wadr == `PCSC_IDX_BW && !st_q.autob
      |=> st_q.trk == $past(ahb_in.hwdata[`PCSC_BW_TRK]);
  endproperty
  a_trk_write: assert property (p_trk_write) else $error("tracking bit not written");

  property p_trk_auto;
    @(posedge clk) disable iff (!reset_n)
    clk_en && st_q.autob |=> $stable(st_q.trk);
  endproperty
  a_trk_auto: assert property (p_trk_auto) else $error("tracking bit written in auto");

  property p_lock_sync;
    @(posedge clk) disable iff (!reset_n)
    clk_en |=> st_q.lk_s2 == $past(st_q.lk_s1);
  endproperty
  a_lock_sync: assert property (p_lock_sync) else $error("lock sync stage skipped");

  property p_osc_on;
    @(posedge clk) disable iff (!reset_n)
    clk_en && system_osc_enable |=> osc_enable;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator not enabled");

  property p_loop_stop;
    @(posedge clk) disable iff (!reset_n)
    clk_en && stop_mode |=> !loop_enable;
  endproperty
  a_loop_stop: assert property (p_loop_stop) else $error("loop kept in stop");

  property p_irq_off;
    @(posedge clk) disable iff (!reset_n)
    clk_en && !(st_q.flag && st_q.ie) |=> !lock_change_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");

endmodule

// [sim/pcsc_far_model.sv]
/*
  Far-side model: system unit and analog sources of the clock block.
  Assumes the bench clock; sources run only while the block enables them.
*/
module pcsc_far_model (
  // clock, reset
  input wire logic clk,
  input wire logic reset_n,
  // bench requests
  input wire logic stop_req,
  input wire logic lock_req,
  // enables from the block
  input wire logic osc_enable,
  input wire logic loop_enable,
  // to the block
  output logic crystal_clock,
  output logic vco_clock,
  output logic lock_status,
  output logic track_status,
  output logic system_osc_enable,
  output logic stop_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] xc_q;
  logic [1:0] vc_q;
  assign stop_mode = stop_req;
  assign system_osc_enable = !stop_req;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xc_q <= 2'h0;
      vc_q <= 2'h0;
      crystal_clock <= 1'b0;
      vco_clock <= 1'b0;
      lock_status <= 1'b0;
      track_status <= 1'b0;
    end else begin
      // crystal half period 2 cycles, vco 3; both stand still when disabled
      xc_q <= (osc_enable && xc_q != 2'h1) ? xc_q + 2'h1 : 2'h0;
      vc_q <= (loop_enable && vc_q != 2'h2) ? vc_q + 2'h1 : 2'h0;
      if (osc_enable && xc_q == 2'h1) crystal_clock <= !crystal_clock;
      if (loop_enable && vc_q == 2'h2) vco_clock <= !vco_clock;
      lock_status <= lock_req && loop_enable;
      track_status <= lock_req && loop_enable;
    end
  end
endmodule

// [sim/tb.sv]
/*
  Self-checking bench of the clock select block over AHB-Lite.
  Assumes one slave, so hready follows hreadyout; far side is the model.
*/
`include "pcsc_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, hw, stop_req, lock_req, bprev, cen;
  logic xclk, vclk, lk, trk, sen, stp, bout, irq, oen, len;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata;
  int fail_count, checked, cyc, tog;
  pcsc_pkg::pcsc_ahb_in_s ai;
  pcsc_pkg::pcsc_ahb_out_s ao;
  pcsc_pkg::pcsc_settings_s set;
  assign ai = {1'b1, haddr, htrans, hw, 3'h2, ao.hreadyout, hwdata};
  pcsc_top i_pcsc_top (.clk(clk), .reset_n(reset_n), .clk_en(cen), .ahb_in(ai),
    .ahb_out(ao), .crystal_clock(xclk), .vco_clock(vclk), .lock_status(lk),
    .track_status(trk), .system_osc_enable(sen), .stop_mode(stp),
    .base_clock_out(bout), .lock_change_irq(irq), .osc_enable(oen),
    .loop_enable(len), .pll_settings(set));
  pcsc_far_model i_pcsc_far_model (.clk(clk), .reset_n(reset_n), .stop_req(stop_req),
    .lock_req(lock_req), .osc_enable(oen), .loop_enable(len), .crystal_clock(xclk),
    .vco_clock(vclk), .lock_status(lk), .track_status(trk),
    .system_osc_enable(sen), .stop_mode(stp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (bout !== bprev) tog++;
    bprev = bout;
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      end_sim();
    end
  end
  task end_sim();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task xf(input logic w, input logic [2:0] i, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge clk);
    haddr <= {27'h0, i, 2'h0};
    htrans <= 2'h2;
    hw <= w;
    do @(posedge clk); while (ao.hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (ao.hreadyout !== 1'b1);
    r = ao.hrdata;
  endtask
  task wr(input logic [2:0] i, input logic [31:0] d);
    logic [31:0] r;
    xf(1'b1, i, d, r);
  endtask
  task rc(input logic [2:0] i, input logic [31:0] e);
    logic [31:0] r;
    xf(1'b0, i, 32'h0, r);
    chk($sformatf("reg%0d", i), e, r);
  endtask
  // toggles of the base clock over 240 cycles, one either way for phase
  task tg(input int e);
    int t;
    int n;
    repeat (30) @(posedge clk);
    t = tog;
    repeat (240) @(posedge clk);
    n = tog - t;
    if (n == e - 1 || n == e + 1) n = e;
    chk("toggles", 32'(e), 32'(n));
  endtask
  task t_reset();
    rc(`PCSC_IDX_CTRL, 32'h20);
    rc(`PCSC_IDX_BW, 32'h0);
    rc(`PCSC_IDX_VRS, 32'h40);
    rc(`PCSC_IDX_RDS, 32'h1);
    rc(3'h7, 32'h0);
    wr(`PCSC_IDX_MUL, 32'h123);
    rc(`PCSC_IDX_MUL, 32'h40);
    wr(`PCSC_IDX_CTRL, 32'h29);
    rc(`PCSC_IDX_CTRL, 32'h20);
    chk("loop_en", 32'h1, {31'h0, len});
    $display("test reset done");
  endtask
  task t_prog();
    wr(`PCSC_IDX_CTRL, 32'h0);
    wr(`PCSC_IDX_CTRL, 32'h09);
    rc(`PCSC_IDX_CTRL, 32'h09);
    chk("prescale", 32'h2, {30'h0, set.prescale});
    wr(`PCSC_IDX_MUL, 32'h123);
    rc(`PCSC_IDX_MUL, 32'h123);
    chk("multiplier", 32'h123, {20'h0, set.multiplier});
    wr(`PCSC_IDX_RDS, 32'h5);
    rc(`PCSC_IDX_RDS, 32'h5);
    wr(`PCSC_IDX_VRS, 32'h0);
    wr(`PCSC_IDX_CTRL, 32'h29);
    wr(`PCSC_IDX_CTRL, 32'h39);
    rc(`PCSC_IDX_CTRL, 32'h29);
    wr(`PCSC_IDX_CTRL, 32'h09);
    wr(`PCSC_IDX_VRS, 32'h40);
    wr(`PCSC_IDX_BW, 32'h0);
    wr(`PCSC_IDX_CTRL, 32'h39);
    rc(`PCSC_IDX_CTRL, 32'h29);
    $display("test program done");
  endtask
  task t_sel();
    int t;
    wr(`PCSC_IDX_CTRL, 32'h39);
    repeat (2) @(posedge clk);
    t = tog;
    repeat (8) @(posedge clk);
    chk("frozen", 32'(t), 32'(tog));
    tg(40);
    rc(`PCSC_IDX_CTRL, 32'h39);
    wr(`PCSC_IDX_CTRL, 32'h19);
    rc(`PCSC_IDX_CTRL, 32'h39);
    wr(`PCSC_IDX_CTRL, 32'h29);
    tg(60);
    $display("test select done");
  endtask
  task t_freeze();
    int t;
    cen <= 1'b0;
    repeat (2) @(posedge clk);
    t = tog;
    repeat (16) @(posedge clk);
    chk("frozen_en", 32'(t), 32'(tog));
    cen <= 1'b1;
    tg(60);
    $display("test freeze done");
  endtask
  task t_lock();
    wr(`PCSC_IDX_BW, 32'h80);
    wr(`PCSC_IDX_CTRL, 32'ha9);
    rc(`PCSC_IDX_CTRL, 32'ha9);
    lock_req <= 1'b1;
    repeat (8) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rc(`PCSC_IDX_BW, 32'he0);
    rc(`PCSC_IDX_CTRL, 32'he9);
    rc(`PCSC_IDX_CTRL, 32'ha9);
    chk("irq", 32'h0, {31'h0, irq});
    lock_req <= 1'b0;
    repeat (8) @(posedge clk);
    rc(`PCSC_IDX_CTRL, 32'he9);
    wr(`PCSC_IDX_BW, 32'h0);
    rc(`PCSC_IDX_CTRL, 32'h29);
    wr(`PCSC_IDX_BW, 32'h20);
    rc(`PCSC_IDX_BW, 32'h20);
    wr(`PCSC_IDX_BW, 32'h0);
    $display("test lock done");
  endtask
  task t_stop();
    wr(`PCSC_IDX_CTRL, 32'h39);
    repeat (30) @(posedge clk);
    stop_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk("bout", 32'h0, {31'h0, bout});
    chk("osc_en", 32'h0, {31'h0, oen});
    chk("loop_en", 32'h0, {31'h0, len});
    stop_req <= 1'b0;
    repeat (4) @(posedge clk);
    rc(`PCSC_IDX_CTRL, 32'h29);
    wr(`PCSC_IDX_CFG, 32'h1);
    stop_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk("osc_en", 32'h1, {31'h0, oen});
    stop_req <= 1'b0;
    $display("test stop done");
  endtask
  initial begin
    reset_n = 1'b0;
    hw = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    stop_req = 1'b0;
    lock_req = 1'b0;
    cen = 1'b1;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_prog();
    t_sel();
    t_freeze();
    t_lock();
    t_stop();
    end_sim();
  end
endmodule
